//--- logic/vbsa_top.sv
// Purpose: sdram start address bank for channel 2 and 3 field buffers
// Assumes: single clock pclk, apb register access, engine on pclk
// Notes:   streams 0..5 are c2 ty, c3 ty, c2 by, c3 by, c2 tc, c3 tc
// Behaviour
// - keep writable 32-bit top luma base per channel as area start
// - keep writable 32-bit bottom luma base per channel as area start
// - keep writable 32-bit top chroma base per channel as area start
// - raster mode: first stored data goes exactly to the base address
// - channel 3 luma bases honoured only in channel 3 y/c mux mode
// - channel 2 top chroma base honoured only in channel 0 y/c mode
// - every base reads back what was written, zero after reset
module vbsa_top #(
  parameter int HSZ_W = 12
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [5:0]  field_start,
  input  wire logic [5:0]  data_beat,
  input  wire logic [5:0]  field_stop,
  output logic [5:0][31:0] area_start_q,
  output logic [5:0][31:0] store_addr_q,
  output logic [5:0]       store_active_q,
  output logic [5:0]       base_misaligned_q
);

  // ----------------------------------------
  // declarations
  // ----------------------------------------
  logic [5:0][31:0] base_q;
  logic [3:0]       mode_q;
  logic [31:0]      hsz_q;
  logic [5:0]       honour;
  logic [5:0]       raster;
  logic [5:0]       misaligned;
  logic [5:0][31:0] gen_addr;
  logic [5:0]       gen_active;
  logic [31:0]      rd_data;
  logic             addr_hit;
  logic             wr_stb;
  logic [31:0]      status;
  logic [31:0]      mode_word;

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  // zero count of the sub-picture size gives the required alignment
  function automatic logic [31:0] subpic_mask(input logic [HSZ_W-1:0] hsz);
    logic [31:0] m;
    m = 32'h0000_0000;
    for (int i = 0; i < HSZ_W; i++) begin
      if (!hsz[i]) begin
        m = {m[30:0], 1'b1};
      end
    end
    return m;
  endfunction : subpic_mask

  function automatic logic [HSZ_W-1:0] hsz_of(input logic [31:0] w,
                                              input logic        ch3);
    logic [HSZ_W-1:0] f;
    f = ch3 ? w[vbsa_pkg::HSZ_CH3_LSB +: HSZ_W] : w[HSZ_W-1:0];
    return f;
  endfunction : hsz_of

  // ----------------------------------------
  // apb slave
  // ----------------------------------------
  vbsa_apb_slave u_apb (
    .pclk     (pclk),
    .presetn  (presetn),
    .psel     (psel),
    .penable  (penable),
    .pwrite   (pwrite),
    .addr_hit (addr_hit),
    .rd_data  (rd_data),
    .pready   (pready),
    .pslverr  (pslverr),
    .prdata   (prdata),
    .wr_stb   (wr_stb)
  );

  // ----------------------------------------
  // address decode
  // ----------------------------------------
  // writes to read-only words are accepted and dropped, no error
  always_comb begin
    addr_hit = 1'b0;
    if (paddr[1:0] == 2'b00) begin
      if (paddr <= vbsa_pkg::OFS_STATUS) begin
        addr_hit = 1'b1;
      end
      if (paddr >= vbsa_pkg::OFS_CUR_ADDR &&
          paddr <= vbsa_pkg::OFS_CUR_ADDR + 8'h14) begin
        addr_hit = 1'b1;
      end
    end
  end

  // ----------------------------------------
  // base registers
  // ----------------------------------------
  // stored regardless of y/c mode so software always reads back
  generate
    for (genvar s = 0; s < vbsa_pkg::NUM_STREAMS; s++) begin : g_base
      localparam logic [7:0] OFS = 8'(4 * s);
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          base_q[s] <= vbsa_pkg::BASE_RESET;
        end else if (wr_stb && paddr == OFS) begin
          base_q[s] <= pwdata;
        end
      end
    end
  endgenerate

  // ----------------------------------------
  // mode and sub-picture size
  // ----------------------------------------
  // reset leaves both channels in raster, y/c mux on
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_q <= vbsa_pkg::MODE_RESET;
    end else if (wr_stb && paddr == vbsa_pkg::OFS_MODE_CTRL) begin
      mode_q <= pwdata[3:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hsz_q <= vbsa_pkg::HSZ_RESET;
    end else if (wr_stb && paddr == vbsa_pkg::OFS_SUBPIC_HSZ) begin
      hsz_q <= pwdata;
    end
  end

  // ----------------------------------------
  // per-stream qualifiers
  // ----------------------------------------
  always_comb begin
    honour = 6'h3f;
    honour[1] = mode_q[vbsa_pkg::MODE_YC_CH3_BIT];
    honour[3] = mode_q[vbsa_pkg::MODE_YC_CH3_BIT];
    honour[4] = mode_q[vbsa_pkg::MODE_YC_CH0_BIT];
  end

  generate
    for (genvar s = 0; s < vbsa_pkg::NUM_STREAMS; s++) begin : g_qual
      localparam bit CH3 = (s % 2) == 1;
      assign raster[s] = CH3 ? mode_q[vbsa_pkg::MODE_RAS_CH3_BIT]
                             : mode_q[vbsa_pkg::MODE_RAS_CH2_BIT];
      // only flagged; the far side is expected to align
      assign misaligned[s] = raster[s]
        ? (base_q[s][vbsa_pkg::RASTER_ALIGN_W-1:0] != '0)
        : ((base_q[s] & subpic_mask(hsz_of(hsz_q, CH3))) != '0);
    end
  endgenerate

  // ----------------------------------------
  // storage address walkers
  // ----------------------------------------
  generate
    for (genvar s = 0; s < vbsa_pkg::NUM_STREAMS; s++) begin : g_gen
      vbsa_stream_addr #(
        .AW (32)
      ) u_gen (
        .pclk     (pclk),
        .presetn  (presetn),
        .honour   (honour[s]),
        .base     (base_q[s]),
        .start    (field_start[s]),
        .beat     (data_beat[s]),
        .stop     (field_stop[s]),
        .addr_q   (gen_addr[s]),
        .active_q (gen_active[s])
      );
    end
  endgenerate

  // ----------------------------------------
  // registered outputs toward the engine
  // ----------------------------------------
  // an ignored base presents zero so the engine cannot use it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      area_start_q <= '0;
    end else begin
      for (int s = 0; s < vbsa_pkg::NUM_STREAMS; s++) begin
        area_start_q[s] <= honour[s] ? base_q[s] : 32'h0000_0000;
      end
    end
  end

  // the walker loads base on start, so the first beat uses it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      store_addr_q <= '0;
    end else begin
      store_addr_q <= gen_addr;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      store_active_q <= 6'h00;
    end else begin
      store_active_q <= gen_active;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      base_misaligned_q <= 6'h00;
    end else begin
      base_misaligned_q <= misaligned;
    end
  end

  // ----------------------------------------
  // read mux
  // ----------------------------------------
  assign mode_word = {28'h0000000, mode_q};
  assign status    = {18'h00000, misaligned, 2'b00, gen_active};

  always_comb begin
    rd_data = 32'h0000_0000;
    case (paddr)
      vbsa_pkg::OFS_C2_TOP_LUMA: rd_data = base_q[0];
      vbsa_pkg::OFS_C3_TOP_LUMA: rd_data = base_q[1];
      vbsa_pkg::OFS_C2_BTM_LUMA: rd_data = base_q[2];
      vbsa_pkg::OFS_C3_BTM_LUMA: rd_data = base_q[3];
      vbsa_pkg::OFS_C2_TOP_CHRO: rd_data = base_q[4];
      vbsa_pkg::OFS_C3_TOP_CHRO: rd_data = base_q[5];
      vbsa_pkg::OFS_MODE_CTRL:   rd_data = mode_word;
      vbsa_pkg::OFS_SUBPIC_HSZ:  rd_data = hsz_q;
      vbsa_pkg::OFS_STATUS:      rd_data = status;
      default: begin
        for (int s = 0; s < vbsa_pkg::NUM_STREAMS; s++) begin
          if (paddr == vbsa_pkg::OFS_CUR_ADDR + 8'(4 * s)) begin
            rd_data = gen_addr[s];
          end
        end
      end
    endcase
  end

endmodule : vbsa_top

//--- shared/vbsa_pkg.sv
// Purpose: shared constants for the video buffer start address bank
// Assumes: apb with 32-bit data, one word per register
// Notes:   stream order is c2 top y, c3 top y, c2 btm y, c3 btm y,
//          c2 top c, c3 top c
package vbsa_pkg;

  // ----------------------------------------
  // register offsets (byte addresses)
  // ----------------------------------------
  localparam logic [7:0] OFS_C2_TOP_LUMA = 8'h00;
  localparam logic [7:0] OFS_C3_TOP_LUMA = 8'h04;
  localparam logic [7:0] OFS_C2_BTM_LUMA = 8'h08;
  localparam logic [7:0] OFS_C3_BTM_LUMA = 8'h0c;
  localparam logic [7:0] OFS_C2_TOP_CHRO = 8'h10;
  localparam logic [7:0] OFS_C3_TOP_CHRO = 8'h14;
  localparam logic [7:0] OFS_MODE_CTRL   = 8'h18;
  localparam logic [7:0] OFS_SUBPIC_HSZ  = 8'h1c;
  localparam logic [7:0] OFS_STATUS      = 8'h20;
  localparam logic [7:0] OFS_CUR_ADDR    = 8'h40;

  // ----------------------------------------
  // field positions and reset values
  // ----------------------------------------
  localparam int          MODE_YC_CH0_BIT  = 0;
  localparam int          MODE_YC_CH3_BIT  = 1;
  localparam int          MODE_RAS_CH2_BIT = 2;
  localparam int          MODE_RAS_CH3_BIT = 3;
  localparam int          HSZ_CH3_LSB      = 16;
  localparam int          STAT_ACT_LSB     = 0;
  localparam int          STAT_MIS_LSB     = 8;
  localparam logic [31:0] BASE_RESET       = 32'h0000_0000;
  localparam logic [3:0]  MODE_RESET       = 4'hf;
  localparam logic [31:0] HSZ_RESET        = 32'h0000_0000;
  localparam int          RASTER_ALIGN_W   = 3;
  localparam logic [31:0] BEAT_BYTES       = 32'h0000_0008;
  localparam int          NUM_STREAMS      = 6;

  // ----------------------------------------
  // stream engine states
  // ----------------------------------------
  typedef enum logic [1:0] {
    GEN_IDLE = 2'b01,
    GEN_RUN  = 2'b10
  } vbsa_gen_state_type;

endpackage : vbsa_pkg

//--- logic/vbsa_apb_slave.sv
// Purpose: apb handshake for the start address bank
// Assumes: one wait state; read data is captured in the setup cycle
// Notes:   every bus output comes from a flip-flop
module vbsa_apb_slave (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic        addr_hit,
  input  wire logic [31:0] rd_data,
  output logic             pready,
  output logic             pslverr,
  output logic [31:0]      prdata,
  output logic             wr_stb
);

  logic setup;

  // ----------------------------------------
  // phase decode
  // ----------------------------------------
  // answers are prepared in setup so outputs stay registered
  assign setup  = psel & ~penable;
  assign wr_stb = psel & penable & pwrite & pready & addr_hit;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= setup;
      pslverr <= setup & ~addr_hit;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (setup && !pwrite && addr_hit) begin
      prdata <= rd_data;
    end else if (setup) begin
      prdata <= 32'h0000_0000;
    end
  end

endmodule : vbsa_apb_slave

//--- logic/vbsa_stream_addr.sv
// Purpose: storage address walker for one field component
// Assumes: start, beat and stop are pulses from same-clock logic
// Notes:   base is snapshotted at start, later writes wait a field
module vbsa_stream_addr #(
  parameter int AW = 32
) (
  input  wire logic          pclk,
  input  wire logic          presetn,
  input  wire logic          honour,
  input  wire logic [AW-1:0] base,
  input  wire logic          start,
  input  wire logic          beat,
  input  wire logic          stop,
  output logic [AW-1:0]      addr_q,
  output logic               active_q
);

  vbsa_pkg::vbsa_gen_state_type state_q;

  // ----------------------------------------
  // field sequencing
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= vbsa_pkg::GEN_IDLE;
    end else begin
      case (state_q)
        vbsa_pkg::GEN_IDLE: begin
          if (start && honour) begin
            state_q <= vbsa_pkg::GEN_RUN;
          end
        end
        vbsa_pkg::GEN_RUN: begin
          if (stop || !honour) begin
            state_q <= vbsa_pkg::GEN_IDLE;
          end
        end
        default: begin
          state_q <= vbsa_pkg::GEN_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------
  // address walk
  // ----------------------------------------
  // start beats a same-cycle beat: the first data lands on base
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      addr_q <= '0;
    end else if (start && honour) begin
      addr_q <= base;
    end else if (beat && state_q == vbsa_pkg::GEN_RUN) begin
      addr_q <= addr_q + vbsa_pkg::BEAT_BYTES[AW-1:0];
    end
  end

  assign active_q = (state_q == vbsa_pkg::GEN_RUN);

endmodule : vbsa_stream_addr

//--- tb/vbsa_monitor.sv
// Purpose: bus and base register checks beside vbsa_top
// Assumes: one wait state apb; bases and mode shadowed from bus writes
// Notes:   area start lag is the designer's, so it is judged 3 quiet cycles on
module vbsa_monitor (
  input wire logic             pclk,
  input wire logic             presetn,
  input wire logic             psel,
  input wire logic             penable,
  input wire logic             pwrite,
  input wire logic [7:0]       paddr,
  input wire logic [31:0]      pwdata,
  input wire logic [31:0]      prdata,
  input wire logic             pready,
  input wire logic             pslverr,
  input wire logic [5:0]       field_start,
  input wire logic [5:0][31:0] area_start_q,
  input wire logic [5:0][31:0] store_addr_q,
  input wire logic [5:0]       store_active_q
);
  // ----------------------------------------
  // shadow state
  // ----------------------------------------
  logic [31:0] base_q [6];
  logic [3:0]  mode_q;
  logic [1:0]  quiet_q;
  logic [5:0]  hon;
  logic        wr_ok;
  assign wr_ok = psel && penable && pready && pwrite && !pslverr;
  assign hon   = {1'b1, mode_q[vbsa_pkg::MODE_YC_CH0_BIT], mode_q[vbsa_pkg::MODE_YC_CH3_BIT],
                  1'b1, mode_q[vbsa_pkg::MODE_YC_CH3_BIT], 1'b1};
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_q  <= vbsa_pkg::MODE_RESET;
      quiet_q <= 2'h0;
      for (int i = 0; i < 6; i++) base_q[i] <= vbsa_pkg::BASE_RESET;
    end else begin
      quiet_q <= wr_ok ? 2'h0 : (quiet_q == 2'h3 ? 2'h3 : quiet_q + 2'h1);
      if (wr_ok && paddr < vbsa_pkg::OFS_MODE_CTRL) base_q[paddr[4:2]] <= pwdata;
      if (wr_ok && paddr == vbsa_pkg::OFS_MODE_CTRL) mode_q <= pwdata[3:0];
    end
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ----------------------------------------
  // assertions
  // ----------------------------------------
  a_ready_one_wait: assert property (psel && !penable |=> pready)
    else $error("pready missing in first access cycle");
  a_ready_in_access: assert property (pready |-> penable && $past(psel) && !$past(penable))
    else $error("pready outside first access cycle");
  a_unaligned_err: assert property (pready && paddr[1:0] != 2'h0 |-> pslverr && prdata == 32'h0)
    else $error("unaligned access not refused");
  a_base_no_err: assert property (pready && paddr < vbsa_pkg::OFS_MODE_CTRL && paddr[1:0] == 2'h0
    |-> !pslverr)
    else $error("base register access refused");
  a_base_read_back: assert property (pready && !pwrite && paddr < vbsa_pkg::OFS_MODE_CTRL
    && paddr[1:0] == 2'h0 |-> prdata == base_q[paddr[4:2]])
    else $error("base read data differs from last write");
  for (genvar s = 0; s < 6; s++) begin : g_s
    a_area_value: assert property (quiet_q == 2'h3 |->
      area_start_q[s] == (hon[s] ? base_q[s] : 32'h0))
      else $error("area start differs from honoured base");
    a_start_loads: assert property (field_start[s] && hon[s] && quiet_q == 2'h3 |->
      ##2 store_active_q[s] && store_addr_q[s] == $past(base_q[s], 2))
      else $error("first store address is not the base");
    a_ignored_start: assert property (field_start[s] && !hon[s] && !store_active_q[s]
      |=> !store_active_q[s] [*2])
      else $error("field started on an ignored base");
  end
  c_read: cover property (pready && !pwrite && !pslverr);
  c_start: cover property (field_start[0] && hon[0]);
  c_ignored: cover property (field_start[1] && !hon[1]);
endmodule : vbsa_monitor

bind vbsa_top vbsa_monitor u_mon (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .field_start(field_start), .area_start_q(area_start_q), .store_addr_q(store_addr_q),
  .store_active_q(store_active_q)
);

//--- tb/vbsa_top_tb.sv
// Purpose: directed register and engine test of vbsa_top
// Assumes: one wait state apb slave, engine on pclk
// Notes:   sub-picture alignment is software's duty; here only the misaligned flags are checked
module vbsa_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------
  // signals
  // ----------------------------------------
  logic             pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [7:0]       paddr;
  logic [31:0]      pwdata, prdata, rdv;
  logic [5:0]       field_start, data_beat, field_stop, store_active_q, base_misaligned_q, hon;
  logic [5:0][31:0] area_start_q, store_addr_q;
  logic [31:0]      model [6];
  int               fails, cmp_count, cyc;

  vbsa_top uut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .field_start(field_start), .data_beat(data_beat), .field_stop(field_stop),
    .area_start_q(area_start_q), .store_addr_q(store_addr_q),
    .store_active_q(store_active_q), .base_misaligned_q(base_misaligned_q)
  );
  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rdv = prdata;
    err = pslverr;
  endtask : apb
  task automatic idle(input int n);
    psel    <= 1'b0;
    penable <= 1'b0;
    repeat (n) @(posedge pclk);
  endtask : idle
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
    if (a < vbsa_pkg::OFS_MODE_CTRL) model[a[4:2]] = d;
    chk("write refused", 32'h0, {31'h0, err});
  endtask : wr
  task automatic rd(input logic [7:0] a);
    apb(1'b0, a, 32'h0);
    chk("read data", model[a[4:2]], rdv);
  endtask : rd
  // area start lags the register by a designer-chosen delay, so wait 3 cycles
  task automatic chk_area();
    idle(3);
    for (int s = 0; s < 6; s++) chk("area start", hon[s] ? model[s] : 32'h0, area_start_q[s]);
  endtask : chk_area
  task automatic field(input int s, input logic live);
    field_start[s] <= 1'b1;
    @(posedge pclk);
    field_start[s] <= 1'b0;
    data_beat[s]   <= 1'b1;
    @(posedge pclk);
    data_beat[s] <= 1'b0;
    @(posedge pclk);
    chk("store active", {31'h0, live}, {31'h0, store_active_q[s]});
    if (live) chk("first address", model[s], store_addr_q[s]);
    @(posedge pclk);
    if (live) chk("beat address", model[s] + 32'h8, store_addr_q[s]);
    field_stop[s] <= 1'b1;
    @(posedge pclk);
    field_stop[s] <= 1'b0;
  endtask : field
  task automatic test_done();
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : test_done
  // ----------------------------------------
  // clock, timeout, sequence
  // ----------------------------------------
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    cyc++;
    if (cyc > 3000) begin
      fails++;
      test_done();
    end
  end
  initial begin
    {presetn, psel, penable, pwrite} = 4'h0;
    {paddr, pwdata} = 40'h0;
    {field_start, data_beat, field_stop} = 18'h0;
    {fails, cmp_count, cyc} = 96'h0;
    hon = 6'h3f;
    for (int s = 0; s < 6; s++) model[s] = 32'h0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    for (int s = 0; s < 6; s++) rd(8'(4 * s));
    chk_area();
    for (int s = 0; s < 6; s++) wr(8'(4 * s), {4'(s + 9), 28'h5a3cf08});
    wr(8'h08, 32'hffff_fff8);
    for (int s = 0; s < 6; s++) rd(8'(4 * s));
    apb(1'b1, 8'h30, 32'h1);
    chk("unmapped refused", 32'h1, {31'h0, err});
    apb(1'b1, 8'h05, 32'h1);
    chk("unaligned refused", 32'h1, {31'h0, err});
    rd(8'h04);
    chk_area();
    for (int s = 0; s < 6; s++) field(s, 1'b1);
    for (int m = 0; m < 4; m++) begin
      wr(vbsa_pkg::OFS_MODE_CTRL, {28'h0, 2'b11, m[1:0]});
      hon = {1'b1, m[0], m[1], 1'b1, m[1], 1'b1};
      chk_area();
      field(1, m[1]);
      field(4, m[0]);
      rd(8'h0c);
      rd(8'h10);
    end
    idle(2);
    chk("raster misaligned", 32'h0, {26'h0, base_misaligned_q});
    wr(vbsa_pkg::OFS_MODE_CTRL, 32'h0000_0003);
    // ch2 size has four zero bits, ch3 none: only ch2 bases need the low nibble clear
    wr(vbsa_pkg::OFS_SUBPIC_HSZ, {4'h0, 12'hfff, 4'h0, 12'hff0});
    idle(2);
    chk("subpic misaligned", 32'h15, {26'h0, base_misaligned_q});
    test_done();
  end
endmodule : vbsa_top_tb
